//--- bench/mdmr_regs_sva.sv
// assertion checker for the memory and display mode register bank
`timescale 1ns/1ps
module mdmr_regs_sva (
  input wire logic                 i_ref_clk,                     // clock
  input wire logic                 i_rst,                         // reset
  input wire logic [7:0]           i_addr,                        // offset
  input wire logic [15:0]          i_wdata,                       // data
  input wire logic                 i_wr,                          // write
  input wire logic                 i_rd,                          // read
  input wire logic [15:0]          o_rdata,                       // rdata
  input wire mdmr_pkg::mdmr_size_t o_memory_size,                 // size
  input wire logic                 o_mem_bus_32,                  // bus
  input wire logic                 o_mem_part_64m,                // part
  input wire logic                 o_mem_two_parts,               // count
  input wire logic [2:0]           o_row_to_column_latency,       // lat
  input wire logic [2:0]           o_precharge_latency,           // lat
  input wire logic [2:0]           o_active_to_precharge_latency, // lat
  input wire logic [2:0]           o_write_to_precharge_latency,  // lat
  input wire mdmr_pkg::mdmr_sync_t o_sync_mode,                   // sync
  input wire logic                 o_sync_out_en,                 // master
  input wire logic                 o_display_halt,                // switch
  input wire logic                 o_ext_sync,                    // tv
  input wire logic [3:0]           o_refresh_count,               // count
  input wire logic                 o_refresh_en,                  // enable
  input wire mdmr_pkg::mdmr_scan_t o_scan_mode,                   // scan
  input wire logic                 o_interlace,                   // interl
  input wire logic                 o_flip_two_vc                  // flip
);
  import mdmr_pkg::*;
  // write decodes; derived outputs land one edge after the write edge and are sampled at the second
  wire mem_wr = i_wr && (i_addr == OFF_MEMORY_MODE);
  wire dsp_wr = i_wr && (i_addr == OFF_DISPLAY_MODE);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  ////////////////////////////////////////////////////////////////////////
  fixed_lat_a:
    assert property (o_active_to_precharge_latency == 3'h5
      && o_write_to_precharge_latency == 3'h2)
    else $error("fixed latency wrong");
  timing_a:
    assert property (mem_wr |-> ##2 (o_row_to_column_latency ==
      ($past(i_wdata[0], 2) ? 3'h2 : 3'h3))
      && o_precharge_latency == o_row_to_column_latency)
    else $error("timing latency wrong");
  size_a:
    assert property (mem_wr |-> ##2 o_memory_size == $past(i_wdata[5:4], 2))
    else $error("size field not applied");
  bus_a:
    assert property (o_mem_bus_32 == o_memory_size[0]
      && o_mem_part_64m == o_memory_size[1]
      && o_mem_two_parts == (o_memory_size == 2'h1))
    else $error("size decode wrong");
  reset_a:
    assert property ($fell(i_rst) |-> o_memory_size == 2'h0
      && o_row_to_column_latency == 3'h3 && o_sync_mode == 2'h2
      && o_refresh_count == 4'h8)
    else $error("reset value wrong");
  sync_a:
    assert property (o_sync_out_en == (o_sync_mode == 2'h0)
      && o_display_halt == (o_sync_mode == 2'h1)
      && o_ext_sync == (o_sync_mode == 2'h2))
    else $error("sync decode wrong");
  refresh_a:
    assert property (o_refresh_en == (o_refresh_count != 4'h0))
    else $error("refresh enable wrong");
  scan_a:
    assert property (dsp_wr |-> ##2 o_scan_mode == $past(i_wdata[5:4], 2)
      && o_interlace == $past(i_wdata[5], 2)
      && o_flip_two_vc == ($past(i_wdata[5:4], 2) == 2'h2))
    else $error("scan decode wrong");
  rdback_a:
    assert property (dsp_wr ##1 (i_rd && i_addr == OFF_DISPLAY_MODE)
      |=> o_rdata == ($past(i_wdata, 2) & 16'h8CFF))
    else $error("display readback wrong");
endmodule : mdmr_regs_sva
////////////////////////////////////////////////////////////////////////////
bind mdmr_regs mdmr_regs_sva chk_u (.i_ref_clk, .i_rst, .i_addr, .i_wdata,
  .i_wr, .i_rd, .o_rdata, .o_memory_size, .o_mem_bus_32, .o_mem_part_64m,
  .o_mem_two_parts, .o_row_to_column_latency, .o_precharge_latency,
  .o_active_to_precharge_latency, .o_write_to_precharge_latency,
  .o_sync_mode, .o_sync_out_en, .o_display_halt, .o_ext_sync,
  .o_refresh_count, .o_refresh_en, .o_scan_mode, .o_interlace,
  .o_flip_two_vc);

//--- bench/mdmr_regs_tb_top.sv
// self-checking bench for the memory and display mode register bank
`timescale 1ns/1ps
module mdmr_regs_tb_top;
  import mdmr_pkg::*;
  logic        i_ref_clk = 1'b0, i_rst = 1'b1, i_wr = 1'b0, i_rd = 1'b0;
  logic        i_pix_valid = 1'b0, i_transparent_check = 1'b0;
  logic [7:0]  i_addr = 8'h00;
  logic [15:0] i_wdata = 16'h0000, i_fg_pixel = 16'h0000;
  logic [15:0] i_bg_pixel = 16'h0000, i_transparent_color = 16'h0000;
  logic [15:0] i_background_origin = 16'h0000;
  logic [13:0] i_bg_start_x = 14'h0, i_bg_start_y = 14'h0, i_bg_dx = 14'h0;
  logic [13:0] i_bg_dy = 14'h0, i_memory_width_x = 14'h0;
  logic [15:0] o_rdata, o_fg_pixel, o_bg_pixel, rdv;
  logic [13:0] o_bg_addr_x, o_bg_addr_y;
  logic [3:0]  o_refresh_count;
  logic [2:0]  o_row_to_column_latency;
  logic        o_mode_error, o_refresh_en, o_fg_transparent, o_bg_valid;
  logic        o_pix_valid, o_bg_transparent;
  mdmr_size_t  o_memory_size;
  mdmr_sync_t  o_sync_mode;
  mdmr_scan_t  o_scan_mode;
  int          miscompares = 0, num_checks = 0;

  mdmr_regs dut_u (.i_ref_clk, .i_rst, .i_addr, .i_wdata, .i_wr, .i_rd,
    .o_rdata, .o_memory_size, .o_mem_bus_32(), .o_mem_part_64m(),
    .o_mem_two_parts(), .o_row_to_column_latency, .o_precharge_latency(),
    .o_active_to_precharge_latency(), .o_write_to_precharge_latency(),
    .o_sync_mode, .o_sync_out_en(), .o_display_halt(), .o_ext_sync(),
    .o_refresh_count, .o_refresh_en, .o_scan_mode, .o_interlace(),
    .o_flip_two_vc(), .o_mode_error, .i_pix_valid, .i_fg_pixel,
    .i_bg_pixel, .i_transparent_check, .i_transparent_color,
    .o_pix_valid, .o_fg_pixel, .o_fg_transparent, .o_bg_valid,
    .o_bg_pixel, .o_bg_transparent, .i_bg_start_x, .i_bg_start_y,
    .i_bg_dx, .i_bg_dy, .i_memory_width_x, .i_background_origin,
    .o_bg_addr_x, .o_bg_addr_y);

  // free-running 100 MHz clock
  always #5 i_ref_clk = ~i_ref_clk;
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // the write strobe stays up so writes may abut; the next read, idle
  // or reset drops it, never twice in one time step
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= d;
    @(posedge i_ref_clk);
  endtask : wr
  // read data stand one cycle only, so sample mid-cycle
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    i_wr   <= 1'b0;
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_ref_clk);
    i_rd <= 1'b0;
    @(negedge i_ref_clk);
    d = o_rdata;
    @(posedge i_ref_clk);
  endtask : rd
  task automatic do_reset(input int n);
    i_rst <= 1'b1;
    i_wr  <= 1'b0;
    repeat (n) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    @(posedge i_ref_clk);
  endtask : do_reset
  // per-component add then drop the half bit
  function automatic logic [15:0] avg565(input logic [15:0] a, b);
    logic [5:0] r, bl;
    logic [6:0] g;
    r  = {1'b0, a[15:11]} + {1'b0, b[15:11]};
    g  = {1'b0, a[10:5]} + {1'b0, b[10:5]};
    bl = {1'b0, a[4:0]} + {1'b0, b[4:0]};
    return {r[5:1], g[6:1], bl[5:1]};
  endfunction : avg565
  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset_vals;
    rd(OFF_MEMORY_MODE, rdv);
    chk(rdv, 16'h0000);
    rd(OFF_DISPLAY_MODE, rdv);
    chk(rdv & 16'hFFCF, 16'h0088);
    chk({12'h0, o_refresh_count}, 16'h0008);
    $display("test reset_vals done");
  endtask : t_reset_vals
  task automatic t_mem;
    logic [15:0] d;
    for (int i = 0; i < 8; i++) begin
      d = {10'h0, i[2:1], 3'h0, i[0]};
      wr(OFF_MEMORY_MODE, d);
      rd(OFF_MEMORY_MODE, rdv);
      chk(rdv, d);
      chk({14'h0, o_memory_size}, {14'h0, i[2:1]});
      chk({13'h0, o_row_to_column_latency}, i[0] ? 16'h2 : 16'h3);
    end
    // reserved bits and an unmapped offset must not store anything
    wr(OFF_MEMORY_MODE, 16'hFFFF);
    wr(8'h06, 16'hFFFF);
    rd(8'h06, rdv);
    chk(rdv, 16'h0000);
    rd(OFF_MEMORY_MODE, rdv);
    chk(rdv, 16'h0031);
    $display("test mem done");
  endtask : t_mem
  task automatic t_disp;
    logic [15:0] d;
    for (int i = 0; i < 4; i++) begin
      d = {8'h0, i[1:0], 2'(3 - i), 4'(i * 5)};
      wr(OFF_DISPLAY_MODE, d);
      rd(OFF_DISPLAY_MODE, rdv);
      chk(rdv, d);
      chk({15'h0, o_mode_error}, {15'h0, i >= 2});
      chk({15'h0, o_refresh_en}, {15'h0, i != 0});
    end
    $display("test disp done");
  endtask : t_disp
  task automatic t_pix(input logic averaging_filter_mode, input logic cmb);
    logic [15:0] av;
    av = avg565(16'hFFFF, 16'h0843);
    wr(OFF_DISPLAY_MODE, {averaging_filter_mode, 4'h0, cmb, 10'h0B3});
    i_wr         <= 1'b0;
    i_bg_start_y <= 14'd1;
    repeat (2) @(posedge i_ref_clk);
    i_pix_valid         <= 1'b1;
    i_fg_pixel          <= 16'hFFFF;
    i_bg_pixel          <= 16'h0843;
    i_transparent_check <= 1'b1;
    i_transparent_color <= av;
    @(posedge i_ref_clk);
    i_pix_valid <= 1'b0;
    @(negedge i_ref_clk);
    chk(o_fg_pixel, averaging_filter_mode ? av : 16'hFFFF);
    chk({15'h0, o_fg_transparent}, {15'h0, averaging_filter_mode});
    chk({15'h0, o_bg_valid}, {15'h0, cmb & ~averaging_filter_mode});
    chk(o_bg_pixel, 16'h0843);
    chk({15'h0, o_pix_valid}, 16'h0001);
    chk({15'h0, o_bg_transparent}, 16'h0000);
    @(posedge i_ref_clk);
    $display("test pix done");
  endtask : t_pix
  task automatic t_wrap(input logic lp);
    wr(OFF_DISPLAY_MODE, {4'h0, lp, 11'h0B3});
    i_wr                <= 1'b0;
    i_bg_start_x        <= 14'd100;
    i_bg_dx             <= 14'd50;
    i_memory_width_x    <= 14'd128;
    i_bg_start_y        <= 14'd500;
    i_bg_dy             <= 14'd20;
    i_background_origin <= 16'h3E00;
    repeat (3) @(posedge i_ref_clk);
    @(negedge i_ref_clk);
    chk({2'h0, o_bg_addr_x}, lp ? 16'd22 : 16'd150);
    chk({2'h0, o_bg_addr_y}, lp ? 16'h3E08 : 16'd520);
    @(posedge i_ref_clk);
    $display("test wrap done");
  endtask : t_wrap
  // a second reset mid-run must keep the scan field
  task automatic t_keep;
    wr(OFF_MEMORY_MODE, 16'h0031);
    wr(OFF_DISPLAY_MODE, 16'h8C6F);
    do_reset(3);
    rd(OFF_DISPLAY_MODE, rdv);
    chk(rdv, 16'h00A8);
    chk({14'h0, o_scan_mode}, 16'h0002);
    rd(OFF_MEMORY_MODE, rdv);
    chk(rdv, 16'h0000);
    $display("test keep done");
  endtask : t_keep
  task automatic summarize;
    $display("checks=%0d mismatches=%0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : summarize
  ////////////////////////////////////////////////////////////////////////
  initial begin
    do_reset(6);
    t_reset_vals;
    t_mem;
    t_disp;
    t_pix(1'b0, 1'b1);
    t_pix(1'b1, 1'b1);
    t_pix(1'b0, 1'b0);
    t_wrap(1'b0);
    t_wrap(1'b1);
    t_keep;
    summarize;
  end
  // watchdog: a hang counts as a mismatch
  initial begin
    #200000;
    miscompares++;
    summarize;
  end
endmodule : mdmr_regs_tb_top

//--- rtl/mdmr_bg_wrap.sv
// background coordinate generation with optional wraparound
`timescale 1ns/1ps
module mdmr_bg_wrap
  import mdmr_pkg::*;
(
  input  wire logic               i_loop_en,  // wraparound on
  input  wire logic [COORD_W-1:0] i_start_x,  // background start x
  input  wire logic [COORD_W-1:0] i_start_y,  // background start y
  input  wire logic [COORD_W-1:0] i_dx,       // offset within screen x
  input  wire logic [COORD_W-1:0] i_dy,       // offset within screen y
  input  wire logic [COORD_W-1:0] i_width_x,  // memory width in pixels
  input  wire logic [15:0]        i_origin,   // background origin reg
  output logic      [COORD_W-1:0] o_x,        // memory x
  output logic      [COORD_W-1:0] o_y         // memory y
);

  logic [COORD_W:0]    x_sum;
  logic [WRAP_Y_W-1:0] y_low;

  always_comb begin
    x_sum = {1'b0, i_start_x} + {1'b0, i_dx};
    y_low = i_start_y[WRAP_Y_W-1:0] + i_dy[WRAP_Y_W-1:0];
    if (i_loop_en) begin
      // one subtraction only: offsets must stay below one memory width
      if (x_sum >= {1'b0, i_width_x}) begin
        o_x = COORD_W'(x_sum - {1'b0, i_width_x});
      end else begin
        o_x = x_sum[COORD_W-1:0];
      end
      // 512-line block chosen by origin bits 13..9
      o_y = {i_origin[ORIGIN_MSB:ORIGIN_LSB], y_low};
    end else begin
      // no wrap: beyond installed memory the picture is undefined
      o_x = x_sum[COORD_W-1:0];
      o_y = COORD_W'(i_start_y + i_dy);
    end
  end

endmodule : mdmr_bg_wrap

//--- rtl/mdmr_pix_avg.sv
// per-component averaging of foreground and background 5:6:5 pixels
`timescale 1ns/1ps
module mdmr_pix_avg
  import mdmr_pkg::*;
(
  input  wire logic [PIX_W-1:0] i_fg,   // foreground pixel
  input  wire logic [PIX_W-1:0] i_bg,   // background pixel
  output logic      [PIX_W-1:0] o_avg   // averaged pixel
);

  logic [5:0] r_sum;
  logic [6:0] g_sum;
  logic [5:0] b_sum;

  // one extra bit per sum so the carry survives before halving
  always_comb begin
    r_sum = {1'b0, i_fg[15:R_LSB]} + {1'b0, i_bg[15:R_LSB]};
    g_sum = {1'b0, i_fg[R_LSB-1:G_LSB]} + {1'b0, i_bg[R_LSB-1:G_LSB]};
    b_sum = {1'b0, i_fg[G_LSB-1:0]} + {1'b0, i_bg[G_LSB-1:0]};
    // dropping bit 0 discards the fraction, no rounding
    o_avg = {r_sum[5:1], g_sum[6:1], b_sum[5:1]};
  end

endmodule : mdmr_pix_avg

//--- rtl/mdmr_pkg.sv
// constants and types shared by the memory and display mode register bank
package mdmr_pkg;

  // register port geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;

  // register offsets
  localparam logic [7:0] OFF_DISPLAY_MODE = 8'h05;
  localparam logic [7:0] OFF_MEMORY_MODE  = 8'h08;

  // memory mode field positions
  localparam int MM_TIMING_BIT = 0;
  localparam int MM_SIZE_LSB   = 4;
  // writable bits; reserved bits store nothing
  localparam logic [15:0] MM_WMASK = 16'h0031;

  // display mode field positions
  localparam int DM_REFRESH_LSB = 0;
  localparam int DM_SCAN_LSB    = 4;
  localparam int DM_SYNC_LSB    = 6;
  localparam int DM_COMBINE_BIT = 10;
  localparam int DM_LOOP_BIT    = 11;
  localparam int DM_FILTER_BIT  = 15;
  localparam logic [15:0] DM_WMASK = 16'h8CFF;

  // reset values
  localparam logic [1:0] SIZE_RST    = 2'h0;
  localparam logic       TIMING_RST  = 1'b0;
  localparam logic [1:0] SYNC_RST    = 2'h2;
  localparam logic [3:0] REFRESH_RST = 4'h8;

  // sequencer latencies in memory clock cycles
  localparam int          LAT_W         = 3;
  localparam logic [2:0] RC_LAT_SLOW   = 3'h3;
  localparam logic [2:0] RC_LAT_FAST   = 3'h2;
  localparam logic [2:0] PRE_LAT_SLOW  = 3'h3;
  localparam logic [2:0] PRE_LAT_FAST  = 3'h2;
  localparam logic [2:0] ACT_PRE_LAT   = 3'h5;
  localparam logic [2:0] WR_PRE_LAT    = 3'h2;

  // background geometry
  localparam int COORD_W    = 14;
  localparam int WRAP_Y_W   = 9;
  localparam int ORIGIN_LSB = 9;
  localparam int ORIGIN_MSB = 13;

  // 5:6:5 pixel layout
  localparam int PIX_W = 16;
  localparam int R_LSB = 11;
  localparam int G_LSB = 5;

  typedef enum logic [1:0] {
    MDMR_SIZE_16M_X16_BUS16 = 2'h0,
    MDMR_SIZE_16M_X2_BUS32  = 2'h1,
    MDMR_SIZE_64M_X16_BUS16 = 2'h2,
    MDMR_SIZE_64M_X32_BUS32 = 2'h3
  } mdmr_size_t;

  typedef enum logic [1:0] {
    MDMR_SYNC_MASTER = 2'h0,
    MDMR_SYNC_SWITCH = 2'h1,
    MDMR_SYNC_EXT_TV = 2'h2,
    MDMR_SYNC_BAD    = 2'h3
  } mdmr_sync_t;

  typedef enum logic [1:0] {
    MDMR_SCAN_NONINT = 2'h0,
    MDMR_SCAN_BAD    = 2'h1,
    MDMR_SCAN_INT    = 2'h2,
    MDMR_SCAN_INT_SV = 2'h3
  } mdmr_scan_t;

endpackage : mdmr_pkg

//--- rtl/mdmr_regs.sv
// memory mode and display mode registers with their steered logic
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/1ps
module mdmr_regs
  import mdmr_pkg::*;
(
  input  wire logic               i_ref_clk,       // 100 MHz clock
  input  wire logic               i_rst,           // sync reset, high
  // register port
  input  wire logic [ADDR_W-1:0]  i_addr,          // register offset
  input  wire logic [DATA_W-1:0]  i_wdata,         // write data
  input  wire logic               i_wr,            // write strobe
  input  wire logic               i_rd,            // read strobe
  output logic      [DATA_W-1:0]  o_rdata,         // read data, next cycle
  // frame memory sequencer configuration
  output mdmr_pkg::mdmr_size_t    o_memory_size,   // size selection
  output logic                    o_mem_bus_32,    // 32-bit data bus
  output logic                    o_mem_part_64m,  // 64-Mbit parts
  output logic                    o_mem_two_parts, // two parts fitted
  output logic      [LAT_W-1:0]   o_row_to_column_latency,    // cycles
  output logic      [LAT_W-1:0]   o_precharge_latency,        // cycles
  output logic      [LAT_W-1:0]   o_active_to_precharge_latency, // cycles
  output logic      [LAT_W-1:0]   o_write_to_precharge_latency,  // cycles
  // display timing configuration
  output mdmr_pkg::mdmr_sync_t    o_sync_mode,     // sync mode field
  output logic                    o_sync_out_en,   // drive sync pins
  output logic                    o_display_halt,  // switching mode
  output logic                    o_ext_sync,      // external tv sync
  output logic      [3:0]         o_refresh_count, // refreshes per line
  output logic                    o_refresh_en,    // refresh timing on
  output mdmr_pkg::mdmr_scan_t    o_scan_mode,     // scan mode field
  output logic                    o_interlace,     // interlaced scan
  output logic                    o_flip_two_vc,   // flip every 2 vc
  output logic                    o_mode_error,    // prohibited code set
  // pixel path
  input  wire logic               i_pix_valid,     // pixel pair valid
  input  wire logic [PIX_W-1:0]   i_fg_pixel,      // foreground pixel
  input  wire logic [PIX_W-1:0]   i_bg_pixel,      // background pixel
  input  wire logic               i_transparent_check, // check enable
  input  wire logic [PIX_W-1:0]   i_transparent_color, // key colour
  output logic                    o_pix_valid,     // outputs valid
  output logic      [PIX_W-1:0]   o_fg_pixel,      // foreground out
  output logic                    o_fg_transparent, // fg is key colour
  output logic                    o_bg_valid,      // bg screen shown
  output logic      [PIX_W-1:0]   o_bg_pixel,      // background out
  output logic                    o_bg_transparent, // bg is key colour
  // background addressing
  input  wire logic [COORD_W-1:0] i_bg_start_x,    // start x
  input  wire logic [COORD_W-1:0] i_bg_start_y,    // start y
  input  wire logic [COORD_W-1:0] i_bg_dx,         // offset x
  input  wire logic [COORD_W-1:0] i_bg_dy,         // offset y
  input  wire logic [COORD_W-1:0] i_memory_width_x, // memory width
  input  wire logic [15:0]        i_background_origin, // origin reg
  output logic      [COORD_W-1:0] o_bg_addr_x,     // memory x
  output logic      [COORD_W-1:0] o_bg_addr_y      // memory y
);

  ////////////////////////////////////////////////////////////////////////
  // register state

  logic [1:0] memory_size_r;
  logic       memory_timing_sel_r;
  logic       averaging_filter_mode_r;
  logic       background_loop_bit_r;
  logic       background_combine_r;
  logic [1:0] sync_mode_r;
  logic [1:0] scan_mode_r;
  logic [3:0] row_renew_count_r;

  logic       wr_mem;
  logic       wr_disp;
  logic [15:0] mm_view;
  logic [15:0] dm_view;

  // decode a write or read strobe against one offset
  function automatic logic hit(input logic [ADDR_W-1:0] addr,
                               input logic [ADDR_W-1:0] off);
    hit = (addr == off);
  endfunction : hit

  assign wr_mem  = i_wr && hit(i_addr, OFF_MEMORY_MODE);
  assign wr_disp = i_wr && hit(i_addr, OFF_DISPLAY_MODE);

  // register images as software reads them, reserved bits zero
  always_comb begin
    mm_view = 16'h0000;
    mm_view[MM_SIZE_LSB +: 2] = memory_size_r;
    mm_view[MM_TIMING_BIT]    = memory_timing_sel_r;
    dm_view = 16'h0000;
    dm_view[DM_FILTER_BIT]      = averaging_filter_mode_r;
    dm_view[DM_LOOP_BIT]        = background_loop_bit_r;
    dm_view[DM_COMBINE_BIT]     = background_combine_r;
    dm_view[DM_SYNC_LSB +: 2]   = sync_mode_r;
    dm_view[DM_SCAN_LSB +: 2]   = scan_mode_r;
    dm_view[DM_REFRESH_LSB +: 4] = row_renew_count_r;
  end

  ////////////////////////////////////////////////////////////////////////
  // memory mode register

  // reserved bits are masked off, so stray ones are never stored
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      memory_size_r       <= SIZE_RST;
      memory_timing_sel_r <= TIMING_RST;
    end else if (wr_mem) begin
      memory_size_r       <= i_wdata[MM_SIZE_LSB +: 2] &
                             MM_WMASK[MM_SIZE_LSB +: 2];
      memory_timing_sel_r <= i_wdata[MM_TIMING_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // display mode register, reset part

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      averaging_filter_mode_r <= 1'b0;
      background_loop_bit_r   <= 1'b0;
      background_combine_r    <= 1'b0;
      sync_mode_r             <= SYNC_RST;
      row_renew_count_r       <= REFRESH_RST;
    end else if (wr_disp) begin
      averaging_filter_mode_r <= i_wdata[DM_FILTER_BIT];
      background_loop_bit_r   <= i_wdata[DM_LOOP_BIT];
      background_combine_r    <= i_wdata[DM_COMBINE_BIT];
      sync_mode_r             <= i_wdata[DM_SYNC_LSB +: 2];
      row_renew_count_r       <= i_wdata[DM_REFRESH_LSB +: 4];
    end
  end

  // scan mode survives reset; its power-up value is unknown until the
  // first write, so software must program it once after power-on
  always_ff @(posedge i_ref_clk) begin
    if (wr_disp) begin
      scan_mode_r <= i_wdata[DM_SCAN_LSB +: 2];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read port

  // data stands only in the cycle after the strobe
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_rdata <= 16'h0000;
    end else if (i_rd && hit(i_addr, OFF_MEMORY_MODE)) begin
      o_rdata <= mm_view & MM_WMASK;
    end else if (i_rd && hit(i_addr, OFF_DISPLAY_MODE)) begin
      o_rdata <= dm_view & DM_WMASK;
    end else begin
      o_rdata <= 16'h0000;                       // idle or unmapped
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // sequencer configuration

  // registered one cycle after the field; settles before any access
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_memory_size   <= MDMR_SIZE_16M_X16_BUS16;
      o_mem_bus_32    <= 1'b0;
      o_mem_part_64m  <= 1'b0;
      o_mem_two_parts <= 1'b0;
    end else begin
      o_memory_size   <= mdmr_size_t'(memory_size_r);
      o_mem_bus_32    <= (memory_size_r == MDMR_SIZE_16M_X2_BUS32) ||
                         (memory_size_r == MDMR_SIZE_64M_X32_BUS32);
      o_mem_part_64m  <= memory_size_r[1];
      o_mem_two_parts <= (memory_size_r == MDMR_SIZE_16M_X2_BUS32);
    end
  end

  // row-to-column and precharge latencies follow the timing bit continuously; the other two are fixed
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_row_to_column_latency       <= RC_LAT_SLOW;
      o_precharge_latency           <= PRE_LAT_SLOW;
      o_active_to_precharge_latency <= ACT_PRE_LAT;
      o_write_to_precharge_latency  <= WR_PRE_LAT;
    end else begin
      o_row_to_column_latency <= memory_timing_sel_r ?
                                 RC_LAT_FAST : RC_LAT_SLOW;
      o_precharge_latency     <= memory_timing_sel_r ?
                                 PRE_LAT_FAST : PRE_LAT_SLOW;
      o_active_to_precharge_latency <= ACT_PRE_LAT;
      o_write_to_precharge_latency  <= WR_PRE_LAT;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // display timing configuration

  // prohibited codes are stored as written but flagged
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_sync_mode     <= MDMR_SYNC_EXT_TV;
      o_sync_out_en   <= 1'b0;
      o_display_halt  <= 1'b0;
      o_ext_sync      <= 1'b1;
      o_refresh_count <= REFRESH_RST;
      o_refresh_en    <= 1'b1;
      o_scan_mode     <= MDMR_SCAN_NONINT;
      o_interlace     <= 1'b0;
      o_flip_two_vc   <= 1'b0;
      o_mode_error    <= 1'b0;
    end else begin
      o_sync_mode     <= mdmr_sync_t'(sync_mode_r);
      o_sync_out_en   <= (sync_mode_r == MDMR_SYNC_MASTER);
      o_display_halt  <= (sync_mode_r == MDMR_SYNC_SWITCH);
      o_ext_sync      <= (sync_mode_r == MDMR_SYNC_EXT_TV);
      o_refresh_count <= row_renew_count_r;
      o_refresh_en    <= (row_renew_count_r != 4'h0);
      o_scan_mode     <= mdmr_scan_t'(scan_mode_r);
      o_interlace     <= scan_mode_r[1];
      o_flip_two_vc   <= (scan_mode_r == MDMR_SCAN_INT);
      o_mode_error    <= (sync_mode_r == MDMR_SYNC_BAD) ||
                         (scan_mode_r == MDMR_SCAN_BAD);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pixel path

  logic [PIX_W-1:0] avg_pixel;
  logic [PIX_W-1:0] fg_sel;

  mdmr_pix_avg u_avg (
    .i_fg  (i_fg_pixel),
    .i_bg  (i_bg_pixel),
    .o_avg (avg_pixel)
  );

  // in filter mode the averaged pixel replaces the foreground
  assign fg_sel = averaging_filter_mode_r ? avg_pixel : i_fg_pixel;

  // one pipeline stage; the key compare uses the chosen pixel, so the
  // raw foreground is never checked while filtering
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_pix_valid      <= 1'b0;
      o_fg_pixel       <= 16'h0000;
      o_fg_transparent <= 1'b0;
      o_bg_valid       <= 1'b0;
      o_bg_pixel       <= 16'h0000;
      o_bg_transparent <= 1'b0;
    end else begin
      o_pix_valid      <= i_pix_valid;
      o_fg_pixel       <= fg_sel;
      o_fg_transparent <= i_transparent_check &&
                          (fg_sel == i_transparent_color);
      // bg is folded into fg while filtering, so no separate screen
      o_bg_valid       <= i_pix_valid && background_combine_r &&
                          !averaging_filter_mode_r;
      o_bg_pixel       <= i_bg_pixel;
      o_bg_transparent <= i_transparent_check &&
                          (i_bg_pixel == i_transparent_color);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // background addressing

  logic [COORD_W-1:0] bg_x;
  logic [COORD_W-1:0] bg_y;

  mdmr_bg_wrap u_wrap (
    .i_loop_en (background_loop_bit_r),
    .i_start_x (i_bg_start_x),
    .i_start_y (i_bg_start_y),
    .i_dx      (i_bg_dx),
    .i_dy      (i_bg_dy),
    .i_width_x (i_memory_width_x),
    .i_origin  (i_background_origin),
    .o_x       (bg_x),
    .o_y       (bg_y)
  );

  // addresses registered so every top output leaves a flip-flop
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_bg_addr_x <= 14'h0000;
      o_bg_addr_y <= 14'h0000;
    end else begin
      o_bg_addr_x <= bg_x;
      o_bg_addr_y <= bg_y;
    end
  end

endmodule : mdmr_regs
